// [sfcp_consts.vh]
// Overview of operation
// - First eight bits after select form opcode
// - Bad opcode: ignore input, output stays off
// - Eight-bit register; bits 4-6 read zero, bit 0 follows WAKING_IN
// - Sample on rising, launch on falling edges
// - Mode 3: first rise after initial toggle
// - Clock level at select picks mode 0/3
// - Decode latch and register opcodes
// - Decode read, fast read, write opcodes
// - Nine opcodes including sleep and identity
// - Latch flag clear after power-up
// - Only set-latch command sets latch flag
// - Latch cleared at deselect after writes
// - Bit map: 7 pin enable, 3/2 guard, 1 latch
// - Guard pair selects protected address range
// - Guard bits kept nonvolatile; here every reset reloads GUARD_INIT, so written guard bits are lost
// - Pin enable makes low pin block register write
// - Protect pin never blocks array writes
// - Register read shifts out byte MSB first
// - Register write updates pin enable, guard only
// - One opcode per select cycle
// - Protected burst write stops, drops data
`ifndef SFCP_CONSTS_VH
`define SFCP_CONSTS_VH
`define SFCP_OP_SET_LATCH   8'h06
`define SFCP_OP_CLR_LATCH   8'h04
`define SFCP_OP_READ_CFG    8'h05
`define SFCP_OP_WRITE_CFG   8'h01
`define SFCP_OP_READ_MEM    8'h03
`define SFCP_OP_FAST_READ   8'h0B
`define SFCP_OP_WRITE_MEM   8'h02
`define SFCP_OP_SLEEP       8'hB9
`define SFCP_OP_READ_ID     8'h9F
`define SFCP_BIT_PIN_EN     7
`define SFCP_BIT_GUARD_HI   3
`define SFCP_BIT_GUARD_LO   2
`define SFCP_BIT_LATCH      1
`define SFCP_BIT_BUSY       0
`define SFCP_CFG_RESET      8'h00
`define SFCP_ADDR_QUARTER   14'h3000
`define SFCP_ADDR_HALF      14'h2000
`define SFCP_ADDR_W         14
`endif

// [sfcp_core.v]
`timescale 1ns/10ps
`include "sfcp_consts.vh"
module sfcp_core #(
  parameter GUARD_INIT = 2'b00 // Power-on image of the nonvolatile guard bits
) (
  input  wire        CLK_SYS_IN,
  input  wire        RST_N_IN,
  input  wire        SPI_CS_N_IN,
  input  wire        SPI_SCK_IN,
  input  wire        SPI_SI_IN,
  input  wire        WP_N_IN,
  input  wire        WAKING_IN,
  output reg         SPI_SO_OUT,
  output reg         SPI_SO_OE_OUT,
  output reg         MODE3_OUT,
  output reg  [7:0]  OPCODE_OUT,
  output reg         OPCODE_VALID_OUT,
  output reg         SLEEP_REQ_OUT,
  output reg         MEM_WR_OUT,
  output reg  [13:0] MEM_ADDR_OUT,
  output reg  [7:0]  MEM_DATA_OUT,
  output wire [7:0]  STATUS_OUT
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [1:0] cs_sync;
  reg  [1:0] sck_sync;
  reg  [1:0] si_sync;
  reg  [1:0] wp_sync;
  reg        cs_q;
  reg        sck_q;
  wire       cs_n  = cs_sync[1];
  wire       sck   = sck_sync[1];
  wire       si    = si_sync[1];
  wire       wp_n  = wp_sync[1];

  // ----------------------------------------------------------------
  // Edge detection on the synchronised pins
  // ----------------------------------------------------------------
  // Select edges open and close a cycle
  wire       cs_fall = cs_q & ~cs_n;
  wire       cs_rise = ~cs_q & cs_n;
  // Clock edges; an idle-high clock gives no rise before its first toggle
  wire       sck_rise = ~sck_q & sck;
  wire       sck_fall = sck_q & ~sck;

  // Two flops per select, clock, data and protect input, then edge history
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      cs_sync  <= 2'b11;
      sck_sync <= 2'b00;
      si_sync  <= 2'b00;
      wp_sync  <= 2'b11;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
    end else begin
      cs_sync  <= {cs_sync[0], SPI_CS_N_IN};
      sck_sync <= {sck_sync[0], SPI_SCK_IN};
      si_sync  <= {si_sync[0], SPI_SI_IN};
      wp_sync  <= {wp_sync[0], WP_N_IN};
      cs_q     <= cs_n;
      sck_q    <= sck;
    end
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  // One-hot transfer states
  localparam ST_IDLE = 6'b000001;
  localparam ST_OPC  = 6'b000010;
  localparam ST_ADDR = 6'b000100;
  localparam ST_DATA = 6'b001000;
  localparam ST_OUT  = 6'b010000;
  localparam ST_DEAD = 6'b100000;

  // Shift, address, flag and configuration registers
  reg [5:0]  state;
  reg [2:0]  bit_cnt;
  reg [7:0]  shift_in;
  reg [7:0]  shift_out;
  reg [7:0]  opcode;
  reg        addr_byte;
  reg [15:0] addr_acc;
  reg        stopped;
  reg        latch;
  reg        pin_en;
  reg [1:0]  guard;
  reg        wrote_flag;

  // Byte assembly from the serial input
  wire [7:0] byte_in = {shift_in[6:0], si};
  wire       byte_done = sck_rise & (bit_cnt == 3'd7);

  // ----------------------------------------------------------------
  // Register image
  // ----------------------------------------------------------------
  // Live register image; unused bits read zero
  assign STATUS_OUT = {pin_en, 3'b000, guard, latch, WAKING_IN};

  // ----------------------------------------------------------------
  // Decode and protection helpers
  // ----------------------------------------------------------------
  // Opcode recogniser
  function known_op;
    input [7:0] op;
    begin
      case (op)
        `SFCP_OP_SET_LATCH: known_op = 1'b1;
        `SFCP_OP_CLR_LATCH: known_op = 1'b1;
        `SFCP_OP_READ_CFG:  known_op = 1'b1;
        `SFCP_OP_WRITE_CFG: known_op = 1'b1;
        `SFCP_OP_READ_MEM:  known_op = 1'b1;
        `SFCP_OP_FAST_READ: known_op = 1'b1;
        `SFCP_OP_WRITE_MEM: known_op = 1'b1;
        `SFCP_OP_SLEEP:     known_op = 1'b1;
        `SFCP_OP_READ_ID:   known_op = 1'b1;
        default: known_op = 1'b0;
      endcase
    end
  endfunction

  // Block guard range check
  function guarded;
    input [1:0]  g;
    input [13:0] a;
    begin
      case (g)
        2'b00:   guarded = 1'b0;
        2'b01:   guarded = (a >= `SFCP_ADDR_QUARTER);
        2'b10:   guarded = (a >= `SFCP_ADDR_HALF);
        default: guarded = 1'b1;
      endcase
    end
  endfunction

  // Whether a register write is allowed now
  wire cfg_wr_ok = latch & ~(pin_en & ~wp_n);

  // Array byte may be stored: latch set and burst not yet stopped
  wire mem_wr_ok = latch & ~stopped;
  // Write address falls in the guarded range
  wire addr_guarded = guarded(guard, addr_acc[13:0]);
  // Serial out advances on falling clock edges only, in both modes
  wire launch_edge = sck_fall;
  // A sleep opcode in this cycle asks for low power at deselect
  wire sleep_at_end = (opcode == `SFCP_OP_SLEEP);

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  // Cycle control, decode, protection and serial out
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      // Sequencer and shift state
      state            <= ST_IDLE;
      bit_cnt          <= 3'd0;
      shift_in         <= 8'h00;
      shift_out        <= 8'h00;
      opcode           <= 8'h00;
      addr_byte        <= 1'b0;
      addr_acc         <= 16'h0000;
      stopped          <= 1'b0;
      // Latch and configuration
      latch            <= 1'b0;
      pin_en           <= 1'b0;
      guard            <= GUARD_INIT;
      wrote_flag       <= 1'b0;
      // Outputs idle
      SPI_SO_OUT       <= 1'b0;
      SPI_SO_OE_OUT    <= 1'b0;
      MODE3_OUT        <= 1'b0;
      OPCODE_OUT       <= 8'h00;
      OPCODE_VALID_OUT <= 1'b0;
      SLEEP_REQ_OUT    <= 1'b0;
      MEM_WR_OUT       <= 1'b0;
      MEM_ADDR_OUT     <= 14'h0000;
      MEM_DATA_OUT     <= 8'h00;
    end else begin
      // Single-cycle pulses default low
      OPCODE_VALID_OUT <= 1'b0;
      SLEEP_REQ_OUT    <= 1'b0;
      MEM_WR_OUT       <= 1'b0;
      if (cs_rise) begin
        // Deselect ends the cycle and applies latch clearing
        state         <= ST_IDLE;
        SPI_SO_OE_OUT <= 1'b0;
        if (wrote_flag)
          latch <= 1'b0;
        if (sleep_at_end)
          SLEEP_REQ_OUT <= 1'b1;
        wrote_flag <= 1'b0;
      end else if (cs_fall) begin
        // Mode from clock level at select
        MODE3_OUT         <= sck;
        state             <= ST_OPC;
        // Fresh cycle: clear counter and opcode
        bit_cnt           <= 3'd0;
        opcode            <= 8'h00;
        stopped           <= 1'b0;
        addr_byte         <= 1'b0;
      end else if (!cs_n) begin
        // Shift on rising edges in every state but ST_DEAD
        if (sck_rise && state != ST_DEAD) begin
          shift_in <= byte_in;
          bit_cnt  <= bit_cnt + 3'd1;
        end
        case (state)
          ST_OPC: begin
            // Opcode byte; an unknown code dead-ends the cycle
            if (byte_done) begin
              opcode           <= byte_in;
              OPCODE_OUT       <= byte_in;
              OPCODE_VALID_OUT <= known_op(byte_in);
              if (!known_op(byte_in)) begin
                state <= ST_DEAD;
              end else begin
                case (byte_in)
                  // Latch set at once
                  `SFCP_OP_SET_LATCH: begin
                    latch <= 1'b1;
                    state <= ST_DEAD;
                  end
                  // Latch cleared at deselect
                  `SFCP_OP_CLR_LATCH: begin
                    wrote_flag <= 1'b1;
                    state      <= ST_DEAD;
                  end
                  // Register image loaded for output
                  `SFCP_OP_READ_CFG: begin
                    shift_out <= STATUS_OUT;
                    state     <= ST_OUT;
                  end
                  // One data byte follows
                  `SFCP_OP_WRITE_CFG: begin
                    wrote_flag <= 1'b1;
                    state      <= ST_DATA;
                  end
                  // Two address bytes follow
                  `SFCP_OP_WRITE_MEM: begin
                    wrote_flag <= 1'b1;
                    state      <= ST_ADDR;
                  end
                  // Reads, sleep and identity end here
                  default: state <= ST_DEAD;
                endcase
              end
            end
          end
          // Address, high byte first
          ST_ADDR: begin
            if (byte_done) begin
              addr_acc  <= {addr_acc[7:0], byte_in};
              addr_byte <= 1'b1;
              // Second byte completes the address
              if (addr_byte)
                state <= ST_DATA;
            end
          end
          // Register write or array burst
          ST_DATA: begin
            if (byte_done) begin
              if (opcode == `SFCP_OP_WRITE_CFG) begin
                // Only pin enable and guard take the byte
                if (cfg_wr_ok) begin
                  pin_en <= byte_in[`SFCP_BIT_PIN_EN];
                  guard  <= {byte_in[`SFCP_BIT_GUARD_HI], byte_in[`SFCP_BIT_GUARD_LO]};
                end
                state <= ST_DEAD;
              end else if (mem_wr_ok) begin
                // Array writes gated by latch and guard, never the pin
                // Guarded address stops the burst for good
                if (addr_guarded) begin
                  stopped <= 1'b1;
                end else begin
                  MEM_WR_OUT   <= 1'b1;
                  MEM_ADDR_OUT <= addr_acc[13:0];
                  MEM_DATA_OUT <= byte_in;
                  addr_acc     <= {2'b00, addr_acc[13:0] + 14'd1};
                end
              end
            end
          end
          ST_OUT: begin
            // Launch each bit on falling edge, MSB first
            if (launch_edge) begin
              SPI_SO_OE_OUT <= 1'b1;
              SPI_SO_OUT    <= shift_out[7];
              shift_out     <= {shift_out[6:0], shift_out[7]};
            end
          end
          // Rest of the cycle ignored, output off
          ST_DEAD: SPI_SO_OE_OUT <= 1'b0;
          // Stray code returns to idle
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sfcp_core

// [sfcp_core_sva.sv]
`timescale 1ns/10ps
// ----
// Checker
// ----
module sfcp_core_sva #(parameter GUARD_INIT = 2'h0) (
  input wire        CLK_SYS_IN,
  input wire        RST_N_IN,
  input wire        SPI_CS_N_IN,
  input wire        SPI_SCK_IN,
  input wire        SPI_SI_IN,
  input wire        WP_N_IN,
  input wire        WAKING_IN,
  input wire        SPI_SO_OUT,
  input wire        SPI_SO_OE_OUT,
  input wire        MODE3_OUT,
  input wire        OPCODE_VALID_OUT,
  input wire        SLEEP_REQ_OUT,
  input wire        MEM_WR_OUT,
  input wire [7:0]  OPCODE_OUT,
  input wire [7:0]  MEM_DATA_OUT,
  input wire [7:0]  STATUS_OUT,
  input wire [13:0] MEM_ADDR_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  // Guarded range hit by the current write address
  wire [1:0] g = STATUS_OUT[3:2];
  wire prot = g == 2'h3 || (g == 2'h2 && MEM_ADDR_OUT[13]) || (g == 2'h1 && &MEM_ADDR_OUT[13:12]);
  a_oe_idle_off: assert property (SPI_CS_N_IN [*6] |-> !SPI_SO_OE_OUT)
    else $error("SO driven while deselected");
  a_fixed_bits: assert property (STATUS_OUT[6:4] == 3'h0 && STATUS_OUT[0] == WAKING_IN)
    else $error("fixed status bits wrong");
  a_latch_reset: assert property ($rose(RST_N_IN) |-> !STATUS_OUT[1])
    else $error("latch set after reset");
  a_wr_needs_latch: assert property (MEM_WR_OUT |-> STATUS_OUT[1])
    else $error("write without latch");
  a_wr_guarded: assert property (MEM_WR_OUT |-> !prot)
    else $error("write into guarded range");
  a_latch_by_set: assert property ($rose(STATUS_OUT[1]) |-> OPCODE_OUT == 8'h06)
    else $error("latch set by other opcode");
  a_cfg_guard: assert property (!$stable(STATUS_OUT[7:2]) |-> $past(STATUS_OUT[1])
    && !($past(STATUS_OUT[7]) && !$past(WP_N_IN))) else $error("refused register write");
  a_op_known: assert property (OPCODE_VALID_OUT |-> OPCODE_OUT inside {8'h06, 8'h04, 8'h05,
    8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F}) else $error("unknown opcode accepted");
  a_mode_pick: assert property ($fell(SPI_CS_N_IN) |-> ##5 MODE3_OUT == $past(SPI_SCK_IN, 5))
    else $error("mode pick wrong");
  a_sleep_pulse: assert property (SLEEP_REQ_OUT |-> OPCODE_OUT == 8'hB9 ##1 !SLEEP_REQ_OUT)
    else $error("sleep request wrong");
  c_read_cfg: cover property (OPCODE_VALID_OUT && OPCODE_OUT == 8'h05);
  c_mem_write: cover property (MEM_WR_OUT);
  c_mode3: cover property ($rose(MODE3_OUT));
endmodule // sfcp_core_sva
bind sfcp_core sfcp_core_sva #(.GUARD_INIT(GUARD_INIT)) sfcp_core_sva_inst (.*);

// [sfcp_master.sv]
`timescale 1ns/10ps
// ----
// Serial bus master model
// ----
module sfcp_master (
  input  wire  clk_in,
  input  wire  so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out
);
  // Idle bus at time zero
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end
  // One select cycle of n whole bytes, MSB first, SO taken at the end of each high phase
  task automatic xfer(input bit m3, input int n, input logic [31:0] tx, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge clk_in) sck_out <= m3;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    for (i = n * 8 - 1; i >= 0; i--) begin
      sck_out <= 1'b0;
      si_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      rx = {rx[30:0], so_in};
    end
    sck_out <= m3;
    si_out <= ~si_out;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (12) @(posedge clk_in);
  endtask
endmodule // sfcp_master

// [spi_fram_command_protect_tb.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
// ----
// Testbench
// ----
module spi_fram_command_protect_tb;
  logic        clk, rst_n, cs_n, sck, si, wp_n, waking, so, oe, mode3, vld, slp, mwr;
  logic [7:0]  opc, mdat, stat, ev, cfg;
  logic [13:0] madr;
  logic [21:0] ew;
  logic [31:0] rx;
  logic [7:0]  op_q[$];
  logic [21:0] wr_q[$];
  int          failures = 0, checks_done = 0, m, sleeps = 0;
  logic [7:0]  ops[9] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F};
  logic [7:0]  rsv[4] = '{8'hC3, 8'hC2, 8'h5A, 8'h5B};
  sfcp_core sfcp_core_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .SPI_CS_N_IN(cs_n),
    .SPI_SCK_IN(sck), .SPI_SI_IN(si), .WP_N_IN(wp_n), .WAKING_IN(waking), .SPI_SO_OUT(so),
    .SPI_SO_OE_OUT(oe), .MODE3_OUT(mode3), .OPCODE_OUT(opc), .OPCODE_VALID_OUT(vld),
    .SLEEP_REQ_OUT(slp), .MEM_WR_OUT(mwr), .MEM_ADDR_OUT(madr), .MEM_DATA_OUT(mdat),
    .STATUS_OUT(stat));
  sfcp_master sfcp_master_inst (.clk_in(clk), .so_in(oe ? so : ~so), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    summarize;
  end
  // Send n bytes, noting the opcode pulse expected for a known opcode
  task automatic send(input int n, input logic [31:0] tx);
    if (8'(tx >> (n * 8 - 8)) inside {ops}) op_q.push_back(8'(tx >> (n * 8 - 8)));
    sfcp_master_inst.xfer(m[0], n, tx, rx);
    `CHK(mode3, m[0])
    `CHK(oe, 1'b0)
  endtask
  // Latch, write register, read it back
  task automatic wcfg(input logic [7:0] v);
    send(1, 32'h06);
    send(2, {16'h0, 8'h01, v});
    if (!(cfg[7] && !wp_n)) cfg = v & 8'h8C;
    send(2, {16'h0, 8'h05, 8'h00});
    `CHK(rx[7:0], cfg | {7'h0, waking})
    `CHK(stat[1], 1'b0)
  endtask
  // Latch, then one array byte; noted only if outside the guarded range
  task automatic wmem(input logic [15:0] a, input logic [7:0] v);
    send(1, 32'h06);
    `CHK(stat[1], 1'b1)
    if (!(&cfg[3:2] || (cfg[3:2] == 2'h2 && a[13]) || (cfg[3:2] == 2'h1 && &a[13:12])))
      wr_q.push_back({a[13:0], v});
    send(4, {8'h02, a, v});
  endtask
  // Watch design pulses against the oldest note
  always @(posedge clk) begin
    if (vld === 1'b1) begin
      ev = op_q.size() ? op_q.pop_front() : 8'hxx;
      `CHK(opc, ev)
    end
    if (slp === 1'b1) begin
      sleeps++;
      `CHK(opc, 8'hB9)
    end
    if (mwr === 1'b1) begin
      ew = wr_q.size() ? wr_q.pop_front() : 22'hx;
      `CHK({madr, mdat}, ew)
    end
  end
  // Main sequence in both clock modes
  initial begin
    rst_n <= 1'b0;
    wp_n <= 1'b1;
    waking <= 1'b0;
    cfg = 8'h00;
    m = 0;
    void'($urandom(4224));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (ops[k]) send(1, {24'h0, ops[k]});
    for (m = 0; m < 2; m++) begin
      waking <= 1'($urandom);
      wcfg(8'($urandom));
      wp_n <= 1'b0;
      wcfg(8'($urandom));
      wmem(16'($urandom), 8'($urandom));
      wp_n <= 1'b1;
      wcfg(8'(8'h04 << m));
      wmem(16'h2FFF, 8'h5A);
      wmem(16'hF000, 8'hA5);
      send(1, 32'h06);
      send(1, 32'h04);
      `CHK(stat[1], 1'b0)
      foreach (rsv[k]) send(2, {16'h0, rsv[k], 8'h06});
      `CHK(stat[1], 1'b0)
    end
    `CHK(op_q.size(), 0)
    `CHK(wr_q.size(), 0)
    `CHK(sleeps, 1)
    summarize;
  end
  // Verdict
  task automatic summarize;
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // spi_fram_command_protect_tb
